// File: mtr_regs.vh
`ifndef MTR_REGS_VH
`define MTR_REGS_VH

// Window layout on the telemetry read port
`define MTR_ADDR_W 17
`define MTR_BW_BASE 17'h00000
`define MTR_OCC_BASE 17'h10000
`define MTR_WIN_SEL_BIT 16
`define MTR_BLOCK_BYTES 4096

// Sizes of the telemetry arrays
`define MTR_TAG_W 6
`define MTR_TAG_COUNT 64
`define MTR_MAX_TAG 6'h3f
`define MTR_REGION_W 1
`define MTR_REGION_COUNT 2
`define MTR_BW_IDX_W 7
`define MTR_BW_ENTRIES 128

// Occupancy layout
`define MTR_OCC_CLUMP_SIZE 8
`define MTR_OCC_CLUMP_STRIDE 64
`define MTR_OCC_BLOCK_SIZE_VAL 8'h01

// Bandwidth interleave layout
`define MTR_BW_TAG_GROUP 32
`define MTR_BW_TAG_RUN 8
`define MTR_BW_BLOCK_STEP 4
`define MTR_BW_REGION_BYTES 2048
`define MTR_BW_BLOCK_SIZE_VAL 8'h10

// Field positions
`define MTR_NODATA_BIT 63
`define MTR_OCC_VAL_MSB 62
`define MTR_WRAP_BIT 62
`define MTR_BW_VAL_MSB 61
`define MTR_WORD_BYTES 8

// Reset values and reported constants
`define MTR_COUNTER_RST 64'h0000000000000000
`define MTR_INDEX_VERSION 8'h01

`endif

// File: mtr_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "mtr_regs.vh"

// Turns a byte address into an occupancy tag or a bandwidth
// tag/region pair; offsets that land on no implemented counter miss.
module mtr_decode
(
  input wire [`MTR_ADDR_W-1:0] addr,
  output reg occ_hit,
  output reg [`MTR_TAG_W-1:0] occ_tag,
  output reg bw_hit,
  output reg [`MTR_BW_IDX_W-1:0] bw_idx
);

  wire [15:0] off = addr[15:0];
  wire occ_win = addr[`MTR_WIN_SEL_BIT];
  // Word number inside a bandwidth block, region bit stripped
  wire [7:0] bw_word = off[10:3];
  // Word number inside the occupancy block
  wire [8:0] occ_word = off[11:3];

  always @*
  begin
    // Clump stride equals clump size x 8, so the clumps are dense
    occ_hit = occ_win && (off[15:12] == 4'h0) && (off[2:0] == 3'h0) &&
              (occ_word < `MTR_TAG_COUNT);
    occ_tag = occ_word[`MTR_TAG_W-1:0];
    // Block = ((tag mod 32) / 8) x 4, word = (tag/32) x 8 + tag mod 8
    bw_hit = !occ_win && (off[13:12] == 2'h0) && (off[2:0] == 3'h0) &&
             (bw_word[7:3] < 5'h02);
    // Region sits at 2048-byte steps, only two regions exist
    bw_idx = {off[11], bw_word[3], off[15:14], bw_word[2:0]};
  end

endmodule
`default_nettype wire

// File: mtr_telemetry.v
// How it works
// - Occupancy: 64-bit read-only, no-data bit 63, value 62:0, reset 0
// - Occupancy no-data set: tag unmonitored, reader ignores value.
// - Bandwidth count in bits 61:0, read-only, reset zero.
// - Bandwidth bit 63 is no-data; when set reader ignores bits 61:0.
// - Bandwidth bit 62 reads one after the counter wrapped, else zero.
// - Reading a bandwidth register clears its wrap bit.
// - One occupancy register per tag, tags counted from zero.
// - Occupancy address: clump index times stride plus slot times eight.
// - Occupancy registers lie below base plus size value times 4096.
// - Layout version reads one; software decodes only version one.
// - Bandwidth block offset is ((tag mod 32)/8) times 4 times 4096.
// - In-block offset: ((tag/32)*8 + tag mod 8)*8 plus region*2048.
// - Bandwidth registers lie below base plus size value times 4096.
// - One bandwidth counter per region index for every tag.
// - Per-region counting only while legacy total select is clear.
`timescale 1ns/1ps
`default_nettype none
`include "mtr_regs.vh"

module mtr_telemetry
(
  input wire CORE_CLK,
  input wire RST_B,
  // Memory-mapped read port, same clock as the block
  input wire MMIO_RD,
  input wire MMIO_WR,
  input wire [`MTR_ADDR_W-1:0] MMIO_ADDR,
  input wire [63:0] MMIO_WDATA,
  output reg MMIO_RVALID,
  output reg [63:0] MMIO_RDATA,
  // Domain control bit from the management domain
  input wire LEGACY_TOTAL_SELECT,
  // Occupancy sample from the cache monitor
  input wire OCC_UPDATE,
  input wire [`MTR_TAG_W-1:0] OCC_TAG,
  input wire OCC_NODATA,
  input wire [62:0] OCC_VALUE,
  // Bandwidth traffic event from the memory monitor
  input wire BW_EVENT,
  input wire [`MTR_TAG_W-1:0] BW_TAG,
  input wire [`MTR_REGION_W-1:0] BW_REGION,
  input wire BW_NODATA,
  input wire [15:0] BW_BYTES,
  // Layout descriptors read by firmware
  output reg [7:0] INDEX_VERSION,
  output reg [`MTR_TAG_W-1:0] MAX_TAG,
  output reg [7:0] OCC_BLOCK_SIZE,
  output reg [7:0] BW_BLOCK_SIZE
);

  reg [63:0] occ_mem_r [0:`MTR_TAG_COUNT-1];
  reg [61:0] bw_cnt_r [0:`MTR_BW_ENTRIES-1];
  reg bw_wrap_r [0:`MTR_BW_ENTRIES-1];
  reg bw_nodata_r [0:`MTR_BW_ENTRIES-1];

  wire occ_hit;
  wire [`MTR_TAG_W-1:0] occ_tag;
  wire bw_hit;
  wire [`MTR_BW_IDX_W-1:0] bw_idx;

  mtr_decode u_decode
  (
    .addr(MMIO_ADDR),
    .occ_hit(occ_hit),
    .occ_tag(occ_tag),
    .bw_hit(bw_hit),
    .bw_idx(bw_idx)
  );

  wire [`MTR_BW_IDX_W-1:0] evt_idx = {BW_REGION, BW_TAG};
  // Region-aware counting is off while the legacy total path is chosen
  wire bw_count = BW_EVENT && !LEGACY_TOTAL_SELECT;
  wire [62:0] bw_sum = {1'b0, bw_cnt_r[evt_idx]} + {47'h0, BW_BYTES};
  // A read of the same entry is served from the old value; the wrap
  // bit clears only for the read, a wrapping event in that cycle sets it anew
  wire rd_bw = MMIO_RD && bw_hit;

  reg [63:0] rdata_nxt;

  function [63:0] mtr_bw_word;
    input nodata;
    input wrap;
    input [61:0] cnt;
    begin
      mtr_bw_word = {nodata, wrap, cnt};
    end
  endfunction

  always @*
  begin
    rdata_nxt = 64'h0000000000000000;
    if (occ_hit)
    begin
      rdata_nxt = occ_mem_r[occ_tag];
    end
    else if (bw_hit)
    begin
      rdata_nxt = mtr_bw_word(bw_nodata_r[bw_idx], bw_wrap_r[bw_idx],
                              bw_cnt_r[bw_idx]);
    end
  end

  // Each reset loop has its own index so no variable has two drivers
  integer i;
  integer j;

  // Occupancy array: the monitor overwrites, software only reads
  always @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      for (i = 0; i < `MTR_TAG_COUNT; i = i + 1)
        occ_mem_r[i] <= `MTR_COUNTER_RST;
    end
    else if (OCC_UPDATE)
    begin
      // No-data samples zero the value so stale counts never leak out
      occ_mem_r[OCC_TAG] <= OCC_NODATA ? 64'h8000000000000000 :
                            {1'b0, OCC_VALUE};
    end
  end

  // Bandwidth array; MMIO_WDATA and MMIO_WR never reach it
  always @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      for (j = 0; j < `MTR_BW_ENTRIES; j = j + 1)
      begin
        bw_cnt_r[j] <= 62'h0;
        bw_wrap_r[j] <= 1'b0;
        bw_nodata_r[j] <= 1'b0;
      end
    end
    else
    begin
      if (rd_bw)
        bw_wrap_r[bw_idx] <= 1'b0;
      if (bw_count)
      begin
        if (BW_NODATA)
        begin
          bw_nodata_r[evt_idx] <= 1'b1;
          bw_cnt_r[evt_idx] <= 62'h0;
        end
        else
        begin
          bw_nodata_r[evt_idx] <= 1'b0;
          bw_cnt_r[evt_idx] <= bw_sum[61:0];
          // Carry out of bit 61 means the counter wrapped; set wins
          if (bw_sum[62])
            bw_wrap_r[evt_idx] <= 1'b1;
        end
      end
    end
  end

  // Read answer one cycle after the strobe; writes get no answer
  always @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      MMIO_RVALID <= 1'b0;
      MMIO_RDATA <= 64'h0000000000000000;
      INDEX_VERSION <= 8'h00;
      MAX_TAG <= 6'h00;
      OCC_BLOCK_SIZE <= 8'h00;
      BW_BLOCK_SIZE <= 8'h00;
    end
    else
    begin
      MMIO_RVALID <= MMIO_RD;
      MMIO_RDATA <= MMIO_RD ? rdata_nxt : 64'h0000000000000000;
      INDEX_VERSION <= `MTR_INDEX_VERSION;
      MAX_TAG <= `MTR_MAX_TAG;
      OCC_BLOCK_SIZE <= `MTR_OCC_BLOCK_SIZE_VAL;
      BW_BLOCK_SIZE <= `MTR_BW_BLOCK_SIZE_VAL;
    end
  end

endmodule
`default_nettype wire

// File: mtr_telemetry_unused_marker.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: mtr_chk_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mtr_chk
(
  input wire CORE_CLK,
  input wire RST_B,
  input wire MMIO_RD,
  input wire [16:0] MMIO_ADDR,
  input wire MMIO_RVALID,
  input wire [63:0] MMIO_RDATA,
  input wire BW_EVENT,
  input wire [7:0] INDEX_VERSION,
  input wire [5:0] MAX_TAG,
  input wire [7:0] OCC_BLOCK_SIZE,
  input wire [7:0] BW_BLOCK_SIZE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  a_read_answer: assert property (
    MMIO_RD |=> MMIO_RVALID) else $error("read unanswered");
  a_no_stray: assert property (
    !MMIO_RD |=> !MMIO_RVALID) else $error("stray answer");
  a_idle_zero: assert property (
    !MMIO_RVALID |-> MMIO_RDATA == 64'h0) else $error("idle data");
  a_version_one: assert property (
    $past(RST_B) |-> INDEX_VERSION == 8'h01) else $error("version");
  a_tag_limit: assert property (
    $past(RST_B) |-> MAX_TAG == 6'h3f) else $error("max tag");
  a_occ_span: assert property (
    $past(RST_B) |-> OCC_BLOCK_SIZE == 8'h01) else $error("occ span");
  a_bw_span: assert property (
    $past(RST_B) |-> BW_BLOCK_SIZE == 8'h10) else $error("bw span");
  // A no-data word never carries a stale count in its value bits
  a_nodata_clean: assert property (
    MMIO_RVALID && MMIO_RDATA[63] |-> MMIO_RDATA[61:0] == 62'h0)
    else $error("nodata value");
  a_bw_hole: assert property (
    MMIO_RD && !MMIO_ADDR[16] && MMIO_ADDR[13:12] != 2'h0
    |=> MMIO_RDATA == 64'h0) else $error("hole not zero");
  // No event between two reads of one entry, so the wrap flag must be clear
  a_wrap_clear: assert property (
    MMIO_RD && !MMIO_ADDR[16] && !BW_EVENT ##1 !BW_EVENT ##1
    MMIO_RD && MMIO_ADDR == $past(MMIO_ADDR, 2)
    |=> !MMIO_RDATA[62]) else $error("wrap kept");
  c_nodata: cover property (MMIO_RVALID && MMIO_RDATA[63]);
  c_count: cover property (MMIO_RVALID && MMIO_RDATA[61:0] != 62'h0);
  c_reread: cover property (MMIO_RD ##2 MMIO_RD);
  // Wrap needs about 2^62 bytes of traffic, so short runs leave this open
  c_wrap: cover property (MMIO_RD && !MMIO_ADDR[16] ##1 MMIO_RDATA[62]);
endmodule
bind mtr_telemetry mtr_chk chk_u (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
  .MMIO_RD(MMIO_RD), .MMIO_ADDR(MMIO_ADDR), .MMIO_RVALID(MMIO_RVALID),
  .MMIO_RDATA(MMIO_RDATA), .BW_EVENT(BW_EVENT),
  .INDEX_VERSION(INDEX_VERSION), .MAX_TAG(MAX_TAG),
  .OCC_BLOCK_SIZE(OCC_BLOCK_SIZE), .BW_BLOCK_SIZE(BW_BLOCK_SIZE));
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  reg clk = 0, rst_b = 0, rd = 0, wr = 0, leg = 0, ou = 0, ond = 0;
  reg be = 0, br = 0, bnd = 0;
  reg [16:0] a = 0;
  reg [63:0] wd = 0;
  reg [5:0] ot = 0, bt = 0;
  reg [62:0] ov = 0;
  reg [15:0] bb = 0;
  wire rv;
  wire [63:0] rdat;
  wire [7:0] ver, obs, bbs;
  wire [5:0] mt;
  integer mismatches = 0, comparisons = 0, cyc = 0, t;
  mtr_telemetry dut_u (.CORE_CLK(clk), .RST_B(rst_b), .MMIO_RD(rd),
    .MMIO_WR(wr), .MMIO_ADDR(a), .MMIO_WDATA(wd), .MMIO_RVALID(rv),
    .MMIO_RDATA(rdat), .LEGACY_TOTAL_SELECT(leg), .OCC_UPDATE(ou),
    .OCC_TAG(ot), .OCC_NODATA(ond), .OCC_VALUE(ov), .BW_EVENT(be),
    .BW_TAG(bt), .BW_REGION(br), .BW_NODATA(bnd), .BW_BYTES(bb),
    .INDEX_VERSION(ver), .MAX_TAG(mt), .OCC_BLOCK_SIZE(obs),
    .BW_BLOCK_SIZE(bbs));
  initial forever #2.5 clk = ~clk;
  function [16:0] oa(input [5:0] g);
    oa = 17'h10000 + g * 8;
  endfunction
  function [16:0] ba(input [5:0] g, input r);
    ba = g[4:3] * 17'h4000 + (g[5] * 8 + g[2:0]) * 8 + r * 17'h800;
  endfunction
  task chk(input [64:0] s, input [64:0] e);
  begin
    comparisons = comparisons + 1;
    if (s !== e)
    begin
      mismatches = mismatches + 1;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  end
  endtask
  task read_reg(input [16:0] ad, input [63:0] e);
  begin
    @(posedge clk);
    rd <= 1'b1;
    a <= ad;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({rv, rdat}, {1'b1, e});
  end
  endtask
  // Both event ports fire in the same cycle when o is set
  task ev(input [5:0] g, input o, input r, input nd, input [15:0] n);
  begin
    @(posedge clk);
    {ou, ot, ond, ov} <= {o, g, g == 6'h05, g, 57'h1};
    {be, bt, br, bnd, bb} <= {1'b1, g, r, nd, n};
    @(posedge clk);
    {ou, be} <= 2'b00;
  end
  endtask
  task report_and_stop;
  begin
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 chk(ver, 8'h01);
    chk(mt, 6'h3f);
    chk(obs, 8'h01);
    chk(bbs, 8'h10);
    for (t = 0; t < 64; t = t + 1)
    begin
      read_reg(oa(t[5:0]), 64'h0);
      read_reg(ba(t[5:0], 0), 64'h0);
      read_reg(ba(t[5:0], 1), 64'h0);
      ev(t[5:0], 1, 0, 0, 16'h100 + t[5:0]);
      ev(t[5:0], 0, 1, 0, 16'h200 + t[5:0]);
    end
    for (t = 0; t < 64; t = t + 1)
    begin
      read_reg(oa(t[5:0]),
        t == 5 ? {1'b1, 63'h0} : {1'b0, t[5:0], 57'h1});
      read_reg(ba(t[5:0], 0), 64'h100 + t[5:0]);
      read_reg(ba(t[5:0], 1), 64'h200 + t[5:0]);
      read_reg(ba(t[5:0], 1), 64'h200 + t[5:0]);
    end
    ev(3, 0, 1, 1, 16'h7);
    read_reg(ba(3, 1), {1'b1, 63'h0});
    ev(3, 0, 1, 0, 16'h5);
    read_reg(ba(3, 1), 64'h5);
    @(posedge clk) leg <= 1'b1;
    ev(0, 0, 0, 0, 16'hffff);
    read_reg(ba(0, 0), 64'h100);
    @(posedge clk) {leg, wr, a, wd} <= {2'b01, oa(7), ~64'h0};
    @(posedge clk) wr <= 1'b0;
    #1 chk(rv, 1'b0);
    read_reg(oa(7), {7'h07, 57'h1});
    read_reg(17'h01000, 64'h0);
    read_reg(17'h00080, 64'h0);
    read_reg(17'h10004, 64'h0);
    read_reg(17'h10200, 64'h0);
    // Mid-run reset must clear tag 7 occupancy, tag 3 region 1 bandwidth, the version and max tag
    @(posedge clk) rst_b <= 1'b0;
    #1 chk({rv, ver, mt}, 15'h0000);
    @(posedge clk) rst_b <= 1'b1;
    read_reg(oa(7), 64'h0);
    read_reg(ba(3, 1), 64'h0);
    #1 chk(ver, 8'h01);
    report_and_stop;
  end
endmodule
`default_nettype wire
